// [core/dist_cfg_regs.sv]
/*
  Distributor configuration and identification register bank with the
  lockable shared interrupt state behind it, on an APB slave port.
  Assumes pclk at 200 MHz, asynchronous active-low presetn, and that the
  secure lock arrives from a pin outside the pclk domain.
*/
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dist_cfg_regs
  import dist_cfg_pkg::*;
#(
  parameter logic [4:0] LOCKABLE_SHARED_IRQ_COUNT = 5'h1f,    // lockable interrupts built
  parameter logic TWO_SECURITY_STATES = 1'b1,  // 0: secure only
  parameter int CPU_IF_COUNT = 8,              // 1 to 8
  parameter int IRQ_LINE_COUNT = 1020,         // ids provided
  parameter logic [7:0] PRODUCT_ID = 8'h5a,    // arbitrary value
  parameter logic [11:0] REVISION = 12'h001,   // arbitrary value
  parameter logic [3:0] MAKER_CONT = 4'h3,     // arbitrary value
  parameter logic [6:0] MAKER_CODE = 7'h2a     // arbitrary value
)(
  input wire logic pclk,                // bus clock
  input wire logic presetn,             // async reset, active low
  input wire logic psel,                // apb select
  input wire logic penable,             // apb access phase
  input wire logic pwrite,              // apb direction
  input wire logic [11:0] paddr,        // apb byte address
  input wire logic [31:0] pwdata,       // apb write data
  output logic [31:0] prdata,           // apb read data
  output logic pready,                  // apb ready
  output logic pslverr,                 // apb error, unmapped address
  input wire logic cfg_secure_lock,     // secure configuration lock pin
  output logic [30:0] lockable_shared_irq_secure_out,  // security of lockable interrupts
  output logic [30:0] lockable_shared_irq_enable_out   // enable of lockable interrupts
);

  // lockable ids run up to 32+count-1, so the line count never drops below that
  localparam int MIN_LINES = PRIVATE_IDS + int'(LOCKABLE_SHARED_IRQ_COUNT);
  localparam int LINES_RAW = (IRQ_LINE_COUNT < MIN_LINES) ? MIN_LINES : IRQ_LINE_COUNT;
  localparam int LINES_EFF = (LINES_RAW > MAX_IDS) ? MAX_IDS : LINES_RAW;
  localparam logic [4:0] LINE_GROUPS = 5'((LINES_EFF - 1) / IDS_PER_GROUP);
  localparam logic [2:0] CPU_FIELD = 3'(CPU_IF_COUNT - 1);

  logic lock_meta;
  logic lock_sync;
  logic setup;
  logic write_take;
  logic [31:0] ctrl_type_word;
  logic [31:0] impl_id_word;
  logic hit_ctrl;
  logic hit_impl;
  logic hit_sec;
  logic hit_en;

  lockable_shared_irq_bus_if lbus ();

  function automatic logic [31:0] build_ctrl_type();
    logic [31:0] w;
    w = 32'h0; // reserved ranges stay zero
    w[LOCKABLE_SHARED_IRQ_MSB:LOCKABLE_SHARED_IRQ_LSB] = LOCKABLE_SHARED_IRQ_COUNT;
    w[SEC_BIT] = TWO_SECURITY_STATES;
    w[CPU_MSB:CPU_LSB] = CPU_FIELD;
    w[LINES_MSB:LINES_LSB] = LINE_GROUPS;
    return w;
  endfunction

  function automatic logic [31:0] build_impl_id();
    logic [31:0] w;
    w = 32'h0;
    w[PROD_MSB:PROD_LSB] = PRODUCT_ID;
    w[REV_MSB:REV_LSB] = REVISION;
    w[CONT_MSB:CONT_LSB] = MAKER_CONT;
    w[ZERO_BIT] = 1'b0;
    w[MFR_MSB:MFR_LSB] = MAKER_CODE;
    return w;
  endfunction

  assign ctrl_type_word = build_ctrl_type();
  assign impl_id_word = build_impl_id();

  // lock comes from a pin: two flops before anything reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      lock_meta <= cfg_secure_lock;
      lock_sync <= lock_meta;
    end
  end

  assign hit_ctrl = addr_is(paddr, OFF_CTRL_TYPE);
  assign hit_impl = addr_is(paddr, OFF_IMPL_ID);
  assign hit_sec = addr_is(paddr, OFF_LOCKABLE_SHARED_IRQ_SECURE);
  assign hit_en = addr_is(paddr, OFF_LOCKABLE_SHARED_IRQ_ENABLE);

  // zero wait states: read data is registered in setup so it is ready in access
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign write_take = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= PRDATA_RST;
    end else if (setup) begin
      if (pwrite) begin
        prdata <= PRDATA_RST;
      end else if (hit_ctrl) begin
        prdata <= ctrl_type_word;
      end else if (hit_impl) begin
        prdata <= impl_id_word;
      end else if (hit_sec) begin
        prdata <= {1'b0, lbus.secure};
      end else if (hit_en) begin
        prdata <= {1'b0, lbus.enable};
      end else begin
        prdata <= PRDATA_RST;
      end
    end
  end

  // identification registers answer any access; only holes in the map error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !(hit_ctrl || hit_impl || hit_sec || hit_en);
    end
  end

  // writes to the read-only words fall through with no effect
  assign lbus.wr_secure = write_take && hit_sec;
  assign lbus.wr_enable = write_take && hit_en;
  assign lbus.wdata = pwdata[30:0];
  assign lbus.lock = lock_sync;
  assign lbus.single_state = !TWO_SECURITY_STATES;
  assign lbus.valid_mask = lockable_shared_irq_valid_mask(LOCKABLE_SHARED_IRQ_COUNT);

  lockable_shared_irq_state_regs u_state (
    .pclk(pclk),
    .presetn(presetn),
    .bus(lbus.owner)
  );

  assign lockable_shared_irq_secure_out = lbus.secure;
  assign lockable_shared_irq_enable_out = lbus.enable;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read_setup(logic hit);
    psel && !penable && !pwrite && hit;
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  property p_ctrl_fields;
    s_read_setup(hit_ctrl) ##1 s_access |->
      prdata[LOCKABLE_SHARED_IRQ_MSB:LOCKABLE_SHARED_IRQ_LSB] == LOCKABLE_SHARED_IRQ_COUNT && prdata[CPU_MSB:CPU_LSB] == CPU_FIELD;
  endproperty
  a_ctrl_fields: assert property (p_ctrl_fields)
    else $error("type register count fields wrong");

  property p_sec_flag;
    s_read_setup(hit_ctrl) |=> prdata[SEC_BIT] == TWO_SECURITY_STATES;
  endproperty
  a_sec_flag: assert property (p_sec_flag)
    else $error("security flag wrong");

  property p_cpu_field;
    s_read_setup(hit_ctrl) |=> int'(prdata[CPU_MSB:CPU_LSB]) + 1 == CPU_IF_COUNT;
  endproperty
  a_cpu_field: assert property (p_cpu_field)
    else $error("processor interface field wrong");

  property p_line_groups;
    s_read_setup(hit_ctrl) |=>
      (int'(prdata[LINES_MSB:LINES_LSB]) + 1) * IDS_PER_GROUP >= LINES_EFF &&
      int'(prdata[LINES_MSB:LINES_LSB]) * IDS_PER_GROUP < LINES_EFF;
  endproperty
  a_line_groups: assert property (p_line_groups)
    else $error("line group field wrong");

  property p_private_reserved;
    s_read_setup(hit_ctrl) |=>
      int'(prdata[LINES_MSB:LINES_LSB]) * IDS_PER_GROUP + IDS_PER_GROUP >=
      FIRST_LOCKABLE_SHARED_IRQ_ID + int'(prdata[LOCKABLE_SHARED_IRQ_MSB:LOCKABLE_SHARED_IRQ_LSB]);
  endproperty
  a_private_reserved: assert property (p_private_reserved)
    else $error("lockable ids exceed provided lines");

  property p_id_read;
    s_read_setup(hit_impl) |=> !pslverr && prdata == impl_id_word && prdata[ZERO_BIT] == 1'b0;
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identity register read wrong");

  property p_maker_layout;
    s_read_setup(hit_impl) |=>
      prdata[CONT_MSB:CONT_LSB] == MAKER_CONT && prdata[MFR_MSB:MFR_LSB] == MAKER_CODE;
  endproperty
  a_maker_layout: assert property (p_maker_layout)
    else $error("maker code layout wrong");

  property p_reserved_zero;
    s_read_setup(hit_ctrl) |=> !pslverr && prdata[31:16] == 16'h0 && prdata[9:8] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved type bits not zero");

  // the bench leaves one idle cycle between transfers, so allow one or two cycles
  property p_ro_write_ignored;
    (psel && penable && pwrite && hit_ctrl) ##[1:2] s_read_setup(hit_ctrl) |=>
      prdata == ctrl_type_word;
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored)
    else $error("type register changed after write");

  property p_lock_sync_delay;
    $rose(cfg_secure_lock) ##1 cfg_secure_lock |=> lock_sync;
  endproperty
  a_lock_sync_delay: assert property (p_lock_sync_delay)
    else $error("lock not seen two cycles after pin");

endmodule
`default_nettype wire

// [core/dist_cfg_pkg.sv]
/*
  Constants shared by the distributor configuration and identification bank:
  register offsets, field positions, reset values and decode helpers.
  Assumes a 12-bit APB byte address window and 32-bit data.
*/
package dist_cfg_pkg;

  localparam logic [11:0] OFF_CTRL_TYPE = 12'h004;
  localparam logic [11:0] OFF_IMPL_ID = 12'h008;
  localparam logic [11:0] OFF_LOCKABLE_SHARED_IRQ_SECURE = 12'h010;
  localparam logic [11:0] OFF_LOCKABLE_SHARED_IRQ_ENABLE = 12'h014;

  localparam int LINES_LSB = 0;
  localparam int LINES_MSB = 4;
  localparam int CPU_LSB = 5;
  localparam int CPU_MSB = 7;
  localparam int SEC_BIT = 10;
  localparam int LOCKABLE_SHARED_IRQ_LSB = 11;
  localparam int LOCKABLE_SHARED_IRQ_MSB = 15;
  localparam int MFR_LSB = 0;
  localparam int MFR_MSB = 6;
  localparam int ZERO_BIT = 7;
  localparam int CONT_LSB = 8;
  localparam int CONT_MSB = 11;
  localparam int REV_LSB = 12;
  localparam int REV_MSB = 23;
  localparam int PROD_LSB = 24;
  localparam int PROD_MSB = 31;

  localparam int LOCKABLE_SHARED_IRQ_MAX = 31;
  localparam int FIRST_LOCKABLE_SHARED_IRQ_ID = 32;
  localparam int PRIVATE_IDS = 32;
  localparam int IDS_PER_GROUP = 32;
  localparam int MAX_IDS = 1020;

  localparam logic [30:0] LOCKABLE_SHARED_IRQ_SECURE_RST = 31'h0;
  localparam logic [30:0] LOCKABLE_SHARED_IRQ_ENABLE_RST = 31'h0;
  localparam logic [31:0] PRDATA_RST = 32'h0;

  // bit i set when lockable interrupt i (id 32+i) exists
  function automatic logic [30:0] lockable_shared_irq_valid_mask(input logic [4:0] n);
    logic [30:0] m;
    m = 31'h0;
    for (int i = 0; i < LOCKABLE_SHARED_IRQ_MAX; i++) begin
      m[i] = (5'(i) < n);
    end
    return m;
  endfunction

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction

endpackage

// [core/lockable_shared_irq_bus_if.sv]
/*
  Carrier between the register front end and the lockable interrupt state.
  Assumes both ends share pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface lockable_shared_irq_bus_if;
  logic wr_secure;
  logic wr_enable;
  logic [30:0] wdata;
  logic lock;
  logic single_state;
  logic [30:0] valid_mask;
  logic [30:0] secure;
  logic [30:0] enable;

  modport owner (
    input wr_secure, wr_enable, wdata, lock, single_state, valid_mask,
    output secure, enable
  );
  modport front (
    output wr_secure, wr_enable, wdata, lock, single_state, valid_mask,
    input secure, enable
  );
endinterface
`default_nettype wire

// [core/lockable_shared_irq_state_regs.sv]
/*
  Security and enable state of the lockable shared interrupts.
  Assumes write strobes are one-cycle pulses from the APB front end and the
  lock level is already synchronised to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module lockable_shared_irq_state_regs
  import dist_cfg_pkg::*;
(
  input wire logic pclk,      // bus clock
  input wire logic presetn,   // async reset, active low
  lockable_shared_irq_bus_if.owner bus       // state port
);

  logic [30:0] sec_q;
  logic [30:0] en_q;
  logic [30:0] sec_writable;
  logic [30:0] en_writable;

  // a secure lockable interrupt is frozen while the lock is high
  assign en_writable = bus.valid_mask & ~(bus.lock ? bus.secure : 31'h0);
  // single-state build: every lockable interrupt is secure and stays so
  assign sec_writable = bus.single_state ? 31'h0 : en_writable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q <= LOCKABLE_SHARED_IRQ_SECURE_RST;
    end else if (bus.wr_secure) begin
      sec_q <= (sec_q & ~sec_writable) | (bus.wdata & sec_writable);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= LOCKABLE_SHARED_IRQ_ENABLE_RST;
    end else if (bus.wr_enable) begin
      en_q <= (en_q & ~en_writable) | (bus.wdata & en_writable);
    end
  end

  assign bus.secure = bus.single_state ? bus.valid_mask : (sec_q & bus.valid_mask);
  assign bus.enable = en_q & bus.valid_mask;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_locked_secure_enable_held;
    bus.lock && bus.wr_enable |=> ((en_q & $past(bus.secure)) == ($past(en_q) & $past(bus.secure)));
  endproperty
  a_locked_secure_enable_held: assert property (p_locked_secure_enable_held)
    else $error("enable of a locked secure interrupt changed");

  property p_locked_secure_stays_secure;
    bus.lock && bus.wr_secure |=> ((sec_q & $past(bus.secure)) == ($past(sec_q) & $past(bus.secure)));
  endproperty
  a_locked_secure_stays_secure: assert property (p_locked_secure_stays_secure)
    else $error("security of a locked secure interrupt changed");

endmodule
`default_nettype wire

// [bench/dist_cfg_regs_test.sv]
/*
  Self-checking bench for the distributor configuration and identification bank.
  Assumes the APB slave answers with zero or more wait states, and the lock
  pin reaches writes within three pclk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module dist_cfg_regs_test;
  import dist_cfg_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, cfg_secure_lock;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er;
  logic [30:0] sec_out, en_out;
  int err_count, comparisons;

  // line count below the floor of 32+5 ids, so the field reports group one
  localparam logic [31:0] TYPE_EXP = {16'h0, 5'h05, 1'b1, 2'b00, 3'h2, 5'h01};
  localparam logic [31:0] ID_EXP = {8'h5a, 12'h001, 4'h3, 1'b0, 7'h2a};

  dist_cfg_regs #(
    .LOCKABLE_SHARED_IRQ_COUNT(5'h05),
    .TWO_SECURITY_STATES(1'b1),
    .CPU_IF_COUNT(3),
    .IRQ_LINE_COUNT(20)
  ) DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg_secure_lock(cfg_secure_lock),
    .lockable_shared_irq_secure_out(sec_out),
    .lockable_shared_irq_enable_out(en_out)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic test_done();
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp,
                        input logic experr);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
    chk({nm, "_err"}, {31'h0, er}, {31'h0, experr});
  endtask

  task automatic set_lock(input logic v);
    @(posedge pclk);
    cfg_secure_lock <= v;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_ident();
    rd_chk("type", OFF_CTRL_TYPE, TYPE_EXP, 1'b0);
    rd_chk("ident", OFF_IMPL_ID, ID_EXP, 1'b0);
  endtask

  task automatic t_readonly();
    apb(1'b1, OFF_CTRL_TYPE, 32'hffffffff);
    rd_chk("type_after_wr", OFF_CTRL_TYPE, TYPE_EXP, 1'b0);
    apb(1'b1, OFF_IMPL_ID, 32'h0);
    rd_chk("ident_after_wr", OFF_IMPL_ID, ID_EXP, 1'b0);
    rd_chk("unmapped", 12'h00c, 32'h0, 1'b1);
  endtask

  task automatic t_count();
    apb(1'b1, OFF_LOCKABLE_SHARED_IRQ_ENABLE, 32'hffffffff);
    rd_chk("enable_masked", OFF_LOCKABLE_SHARED_IRQ_ENABLE, 32'h0000001f, 1'b0);
    chk("enable_out", {1'b0, en_out}, 32'h0000001f);
    apb(1'b1, OFF_LOCKABLE_SHARED_IRQ_SECURE, 32'h00000003);
    rd_chk("secure", OFF_LOCKABLE_SHARED_IRQ_SECURE, 32'h00000003, 1'b0);
  endtask

  task automatic t_lock();
    set_lock(1'b1);
    apb(1'b1, OFF_LOCKABLE_SHARED_IRQ_ENABLE, 32'h0);
    // the two secure ones keep their enable, the rest follow the write
    rd_chk("enable_locked", OFF_LOCKABLE_SHARED_IRQ_ENABLE, 32'h00000003, 1'b0);
    apb(1'b1, OFF_LOCKABLE_SHARED_IRQ_SECURE, 32'h00000004);
    rd_chk("secure_locked", OFF_LOCKABLE_SHARED_IRQ_SECURE, 32'h00000007, 1'b0);
    chk("secure_out", {1'b0, sec_out}, 32'h00000007);
    set_lock(1'b0);
    apb(1'b1, OFF_LOCKABLE_SHARED_IRQ_SECURE, 32'h0);
    apb(1'b1, OFF_LOCKABLE_SHARED_IRQ_ENABLE, 32'h0);
    rd_chk("secure_unlocked", OFF_LOCKABLE_SHARED_IRQ_SECURE, 32'h0, 1'b0);
    chk("enable_out_unlocked", {1'b0, en_out}, 32'h0);
  endtask

  task automatic t_reset();
    apb(1'b1, OFF_LOCKABLE_SHARED_IRQ_ENABLE, 32'h00000015);
    @(posedge pclk);
    chk("enable_out_pre_rst", {1'b0, en_out}, 32'h00000015);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("enable_out_rst", {1'b0, en_out}, 32'h0);
    presetn <= 1'b1;
    rd_chk("type_rst", OFF_CTRL_TYPE, TYPE_EXP, 1'b0);
  endtask

  initial begin
    err_count = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cfg_secure_lock = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_ident();
    t_readonly();
    t_count();
    t_lock();
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire
